// ==== hw/zkil_defs.svh ====
/*
 zone key indicator logic: timing counts, register offsets, field
 positions and encodings. Assumes inclusion by bare name.
*/
`ifndef ZKIL_DEFS_SVH
`define ZKIL_DEFS_SVH

`define ZKIL_BLINK_HALF_MS 250
`define ZKIL_CLK_MHZ 250
`define ZKIL_BLINK_CYC (`ZKIL_BLINK_HALF_MS * 1000 * `ZKIL_CLK_MHZ)

`define ZKIL_KEYS_PER_MOD 20
`define ZKIL_MAX_MODS 5

`define ZKIL_REG_CTRL 12'h000
`define ZKIL_REG_SEL 12'h004
`define ZKIL_REG_STAT 12'h008
`define ZKIL_REG_PRESS 12'h00c
`define ZKIL_REG_KEY 12'h010
`define ZKIL_REG_CFG 12'h014
`define ZKIL_REG_ZST 12'h018
`define ZKIL_REG_LAMP 12'h01c

`define ZKIL_CTRL_TEST 0
`define ZKIL_CTRL_ALERT_EN 1
`define ZKIL_CTRL_RST 2'h2
`define ZKIL_STAT_FAIL 0
`define ZKIL_STAT_ACK 1
`define ZKIL_STAT_ALERT 2

`define ZKIL_FN_NONE 3'h0
`define ZKIL_FN_ZONE 3'h1
`define ZKIL_FN_FAIL 3'h2
`define ZKIL_FN_TEST 3'h3
`define ZKIL_FN_MENU 3'h4

`define ZKIL_ZST_W 12
`define ZKIL_RGB_OFF 3'h0
`define ZKIL_RGB_RED 3'h4
`define ZKIL_RGB_GREEN 3'h2
`define ZKIL_RGB_BLUE 3'h1
`define ZKIL_RGB_YELLOW 3'h6
`define ZKIL_RGB_CYAN 3'h3
`define ZKIL_RGB_MAGENTA 3'h5
`define ZKIL_RGB_WHITE 3'h7

`endif

// ==== hw/zkil_pkg.sv ====
/*
 zone key indicator types. Assumes zkil_defs.svh is on the include path.
*/
package zkil_pkg;

	// zone condition bits as reported by the host controller
	typedef struct packed {
		logic delayed;
		logic monitor;
		logic playback;
		logic recording;
		logic icom_up;
		logic icom_req;
		logic locked;
		logic normal;
		logic live;
		logic fail;
		logic warning;
		logic evacuation_state;
	} zkil_zone_t;

	typedef struct packed {
		logic [2:0] rgb;
		logic sel;
	} zkil_lamp_t;

	typedef enum logic [2:0] {
		ZKIL_MENU_HOME = 3'h0,
		ZKIL_MENU_BACK = 3'h1,
		ZKIL_MENU_ENTER = 3'h2,
		ZKIL_MENU_UP = 3'h3,
		ZKIL_MENU_DOWN = 3'h4
	} zkil_menu_t;

	typedef enum logic [2:0] {
		ZKIL_F_IDLE = 3'b001,
		ZKIL_F_FLASH = 3'b010,
		ZKIL_F_STEADY = 3'b100
	} zkil_fail_t;

endpackage

// ==== hw/zkil_top.sv ====
/*
 zone key indicator logic: key lamp and failure sequencing for up to five
 twenty-key extension modules, an APB slave for configuration and zone
 state. Assumes key inputs are raw pins from the keyboard and that the
 host controller writes zone states over APB.
*/
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "zkil_defs.svh"

module zkil_top
	import zkil_pkg::*;
#(
	parameter int NMOD = `ZKIL_MAX_MODS,
	parameter int BLINK_CYC = `ZKIL_BLINK_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NMOD*`ZKIL_KEYS_PER_MOD-1:0] key_in,
	input wire logic talk_key,
	input wire logic failure_present,
	output logic [NMOD*`ZKIL_KEYS_PER_MOD-1:0][2:0] key_rgb,
	output logic [NMOD*`ZKIL_KEYS_PER_MOD-1:0] key_sel_led,
	output logic fail_led,
	output logic alert_out,
	output logic talk_active,
	output logic menu_valid,
	output zkil_menu_t menu_cmd
);

	localparam int NK = NMOD * `ZKIL_KEYS_PER_MOD;
	localparam int KW = $clog2(NK);

	initial
	begin
		if (NMOD < 1 || NMOD > `ZKIL_MAX_MODS)
			$error("extension module count out of range");
		if (BLINK_CYC < 1)
			$error("blink period too short");
	end

	function automatic logic [2:0] zkil_pick(input zkil_zone_t z,
		input logic blink, input logic fail_steady);
		// highest priority condition wins
		if (z.evacuation_state)
			zkil_pick = `ZKIL_RGB_RED;
		else if (z.warning)
			zkil_pick = blink ? `ZKIL_RGB_RED : `ZKIL_RGB_OFF;
		else if (z.live)
			zkil_pick = blink ? `ZKIL_RGB_GREEN : `ZKIL_RGB_OFF;
		else if (z.fail)
			zkil_pick = (fail_steady || blink) ?
				`ZKIL_RGB_YELLOW : `ZKIL_RGB_OFF;
		else if (z.locked)
			zkil_pick = `ZKIL_RGB_YELLOW;
		else if (z.delayed)
			zkil_pick = blink ? `ZKIL_RGB_MAGENTA : `ZKIL_RGB_OFF;
		else if (z.recording)
			zkil_pick = blink ? `ZKIL_RGB_RED : `ZKIL_RGB_OFF;
		else if (z.playback)
			zkil_pick = `ZKIL_RGB_GREEN;
		else if (z.icom_up)
			zkil_pick = `ZKIL_RGB_BLUE;
		else if (z.icom_req)
			zkil_pick = blink ? `ZKIL_RGB_BLUE : `ZKIL_RGB_OFF;
		else if (z.monitor)
			zkil_pick = blink ? `ZKIL_RGB_CYAN : `ZKIL_RGB_OFF;
		else if (z.normal)
			zkil_pick = `ZKIL_RGB_GREEN;
		else
			zkil_pick = `ZKIL_RGB_OFF;
	endfunction

	// key and failure pin synchronisers
	logic [NK-1:0] key_m_q;
	logic [NK-1:0] key_s_q;
	logic [NK-1:0] key_p_q;
	logic [1:0] talk_q;
	logic [1:0] fail_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_m_q <= '0;
			key_s_q <= '0;
			key_p_q <= '0;
			talk_q <= 2'h0;
			fail_q <= 2'h0;
		end
		else
		begin
			key_m_q <= key_in;
			key_s_q <= key_m_q;
			key_p_q <= key_s_q;
			talk_q <= {talk_q[0], talk_key};
			fail_q <= {fail_q[0], failure_present};
		end
	end

	logic [NK-1:0] key_rise;
	assign key_rise = key_s_q & ~key_p_q;
	assign talk_active = talk_q[1];

	// common blink timebase
	logic [31:0] blink_cnt_q;
	logic blink_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b0;
		end
		else if (blink_cnt_q == 32'(BLINK_CYC - 1))
		begin
			blink_cnt_q <= 32'h0;
			blink_q <= ~blink_q;
		end
		else
			blink_cnt_q <= blink_cnt_q + 32'h1;
	end

	// per-key configuration and zone state
	logic [NK-1:0][2:0] fn_q;
	logic [NK-1:0][2:0] menu_q;
	zkil_zone_t [NK-1:0] zst_q;
	logic [NK-1:0] sel_q;
	logic [NK-1:0] press_q;
	logic [KW-1:0] kidx_q;
	logic [1:0] ctrl_q;
	logic fail_ack_pulse;

	// failure sequence
	zkil_fail_t fstate_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fstate_q <= ZKIL_F_IDLE;
		else
			case (fstate_q)
				ZKIL_F_IDLE:
					if (fail_q[1])
						fstate_q <= ZKIL_F_FLASH;
				ZKIL_F_FLASH:
					if (!fail_q[1])
						fstate_q <= ZKIL_F_IDLE;
					else if (fail_ack_pulse)
						fstate_q <= ZKIL_F_STEADY;
				ZKIL_F_STEADY:
					if (!fail_q[1])
						fstate_q <= ZKIL_F_IDLE;
				default:
					fstate_q <= ZKIL_F_IDLE;
			endcase
	end

	logic fail_act;
	logic fail_steady;
	assign fail_act = (fstate_q != ZKIL_F_IDLE);
	assign fail_steady = (fstate_q == ZKIL_F_STEADY);

	// ack when a failure-signalling key is pressed
	logic [NK-1:0] fail_key_hit;
	logic [NK-1:0] menu_hit;
	genvar gi;
	generate
		for (gi = 0; gi < NK; gi++)
		begin : g_key
			assign fail_key_hit[gi] = key_rise[gi] &&
				fn_q[gi] == `ZKIL_FN_FAIL;
			assign menu_hit[gi] = key_rise[gi] &&
				fn_q[gi] == `ZKIL_FN_MENU;

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					key_rgb[gi] <= `ZKIL_RGB_OFF;
				else if (ctrl_q[`ZKIL_CTRL_TEST])
					key_rgb[gi] <= `ZKIL_RGB_WHITE;
				else
					case (fn_q[gi])
						`ZKIL_FN_ZONE:
							key_rgb[gi] <= zkil_pick(zst_q[gi], blink_q,
								fail_steady);
						`ZKIL_FN_FAIL:
							key_rgb[gi] <= (fail_act &&
								(fail_steady || blink_q)) ?
								`ZKIL_RGB_YELLOW : `ZKIL_RGB_OFF;
						default:
							key_rgb[gi] <= `ZKIL_RGB_OFF;
					endcase
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					key_sel_led[gi] <= 1'b0;
				else
					key_sel_led[gi] <= sel_q[gi] || ctrl_q[`ZKIL_CTRL_TEST];
			end
		end
	endgenerate

	assign fail_ack_pulse = |fail_key_hit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fail_led <= 1'b0;
			alert_out <= 1'b0;
		end
		else
		begin
			fail_led <= fail_act || ctrl_q[`ZKIL_CTRL_TEST];
			alert_out <= ctrl_q[`ZKIL_CTRL_TEST] ||
				(fstate_q == ZKIL_F_FLASH &&
				ctrl_q[`ZKIL_CTRL_ALERT_EN]);
		end
	end

	// menu key output: lowest pressed menu key wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			menu_valid <= 1'b0;
			menu_cmd <= ZKIL_MENU_HOME;
		end
		else
		begin
			menu_valid <= |menu_hit;
			for (int i = NK - 1; i >= 0; i--)
				if (menu_hit[i])
					menu_cmd <= zkil_menu_t'(menu_q[i]);
		end
	end

	// apb slave, zero wait states
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign addr_ok = paddr <= `ZKIL_REG_LAMP && paddr[1:0] == 2'h0;
	assign pslverr = psel && penable && !addr_ok;

	logic [KW-1:0] widx;
	assign widx = KW'(pwdata[7:0]);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= `ZKIL_CTRL_RST;
			kidx_q <= '0;
		end
		else if (wr_en && paddr == `ZKIL_REG_CTRL)
			ctrl_q <= pwdata[1:0];
		else if (wr_en && paddr == `ZKIL_REG_KEY && 32'(pwdata[7:0]) < NK)
			kidx_q <= widx;
	end

	// per key tables, written through the index register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fn_q <= '0;
			menu_q <= '0;
			zst_q <= '0;
		end
		else if (wr_en && paddr == `ZKIL_REG_CFG)
		begin
			fn_q[kidx_q] <= pwdata[2:0];
			menu_q[kidx_q] <= pwdata[6:4];
		end
		else if (wr_en && paddr == `ZKIL_REG_ZST)
			zst_q[kidx_q] <= zkil_zone_t'(pwdata[`ZKIL_ZST_W-1:0]);
	end

	// selection lamp and press latch; a new press wins over a clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sel_q <= '0;
			press_q <= '0;
		end
		else
		begin
			for (int i = 0; i < NK; i++)
			begin
				if (key_rise[i] && fn_q[i] == `ZKIL_FN_ZONE)
					sel_q[i] <= ~sel_q[i];
				else if (fn_q[i] != `ZKIL_FN_ZONE)
					sel_q[i] <= 1'b0;
				if (key_rise[i])
					press_q[i] <= 1'b1;
				else if (wr_en && paddr == `ZKIL_REG_PRESS &&
					32'(pwdata[7:0]) == i)
					press_q[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (rd_en)
			case (paddr)
				`ZKIL_REG_CTRL:
					prdata <= {30'h0, ctrl_q};
				`ZKIL_REG_SEL:
					prdata <= 32'(sel_q[kidx_q]);
				`ZKIL_REG_STAT:
					prdata <= {29'h0, alert_out, fail_steady, fail_act};
				`ZKIL_REG_PRESS:
					prdata <= 32'(press_q[kidx_q]);
				`ZKIL_REG_KEY:
					prdata <= 32'(kidx_q);
				`ZKIL_REG_CFG:
					prdata <= {25'h0, menu_q[kidx_q], 1'b0, fn_q[kidx_q]};
				`ZKIL_REG_ZST:
					prdata <= 32'(zst_q[kidx_q]);
				`ZKIL_REG_LAMP:
					prdata <= {28'h0, key_rgb[kidx_q], key_sel_led[kidx_q]};
				default:
					prdata <= 32'h0;
			endcase
	end

endmodule

// ==== tb/zkil_host.sv ====
/*
 host controller model: apb master for configuration and zone
 state, and the failure level. assumes one pclk.
*/
`timescale 1ns/1ps
module zkil_host
(
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic failure_present
);
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, failure_present} = '0;
	end

	// released address and data invert so stale values never match
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	task put_fail(input logic v);
		@(posedge pclk);
		failure_present <= v;
	endtask
endmodule

// ==== tb/zkil_top_props.sv ====
/*
 port assertions for the zone key indicator logic.
 assumes binding into zkil_top and a single pclk domain.
*/
`timescale 1ns/1ps
`include "zkil_defs.svh"
module zkil_top_props
	import zkil_pkg::*;
#(
	parameter int NMOD = 5
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NMOD*`ZKIL_KEYS_PER_MOD-1:0] key_in,
	input wire logic failure_present,
	input wire logic [NMOD*`ZKIL_KEYS_PER_MOD-1:0][2:0] key_rgb,
	input wire logic [NMOD*`ZKIL_KEYS_PER_MOD-1:0] key_sel_led,
	input wire logic fail_led,
	input wire logic alert_out,
	input wire logic menu_valid,
	input wire zkil_menu_t menu_cmd
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_FAIL_LED_ON: assert property (
		failure_present [*5] |-> fail_led)
		else $error("collective lamp dark during failure");
	AST_FAIL_LED_OFF: assert property (
		(!failure_present) [*5] ##0 key_rgb[0] != 3'h7 |-> !fail_led)
		else $error("collective lamp lit without failure");
	AST_ALERT_LED: assert property (
		$rose(alert_out) |-> ##[0:2] fail_led)
		else $error("alert without failure lamp");
	AST_MENU_PULSE: assert property (
		menu_valid |=> !menu_valid)
		else $error("menu strobe longer than one cycle");
	AST_MENU_CODE: assert property (
		menu_valid |-> menu_cmd <= ZKIL_MENU_DOWN)
		else $error("menu command out of range");
	AST_ERR_PHASE: assert property (
		pslverr |-> psel && penable)
		else $error("slave error outside access phase");
	AST_READY: assert property (
		psel && penable |-> pready)
		else $error("access phase stalled");
	AST_SEL_CAUSE: assert property (
		$changed(key_sel_led[0]) |-> $past(key_in[0], 2) ||
		key_rgb[0] == 3'h7 || $past(key_rgb[0]) == 3'h7)
		else $error("selection lamp moved without a press");

	cover property ($rose(fail_led));
	cover property (menu_valid);
	cover property (pslverr);
	cover property ($rose(key_sel_led[0]));
endmodule

bind zkil_top zkil_top_props #(.NMOD(NMOD)) i_props (.*);

// ==== tb/zkil_top_tb.sv ====
/*
 self-checking bench for the zone key indicator logic.
 assumes one extension module and a four-cycle blink half period.
*/
`timescale 1ns/1ps
`include "zkil_defs.svh"
module zkil_top_tb
	import zkil_pkg::*;
;
	localparam int NK = `ZKIL_KEYS_PER_MOD;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic talk_key, failure_present, fail_led, alert_out;
	logic talk_active, menu_valid;
	zkil_menu_t menu_cmd;
	logic [11:0] paddr, z;
	logic [31:0] pwdata, prdata, q;
	logic [NK-1:0] key_in, key_sel_led;
	logic [NK-1:0][2:0] key_rgb;
	logic [3:0] c;
	int n_fail, checked, k;
	// lamp code per zone bit: {colour, flashing}
	logic [3:0] code [12] = '{4'h8, 4'h9, 4'hd, 4'h5, 4'h4, 4'hc,
		4'h3, 4'h2, 4'h9, 4'h4, 4'h7, 4'hb};
	int prio [12] = '{0, 1, 3, 2, 5, 11, 8, 9, 7, 6, 10, 4};

	zkil_top #(.NMOD(1), .BLINK_CYC(4)) i_dut (.*);
	zkil_host i_host (.*);

	function automatic logic [3:0] model(input logic [11:0] v);
		for (int i = 0; i < 12; i++)
			if (v[prio[i]])
				return code[prio[i]];
		return 4'h1;
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, q, e);
	endtask

	task rd(input logic [11:0] a);
		i_host.xfer(1'b0, a, 32'h0, q, e);
	endtask

	task cfg(input int n, input logic [31:0] f, input logic [11:0] v);
		wr(`ZKIL_REG_KEY, n);
		wr(`ZKIL_REG_CFG, f);
		wr(`ZKIL_REG_ZST, {20'h0, v});
	endtask

	task obs(input int n);
		c = 4'h0;
		repeat (12) @(posedge pclk);
		repeat (16)
		begin
			@(posedge pclk);
			c[3:1] = c[3:1] | key_rgb[n];
			c[0] = c[0] | (key_rgb[n] == 3'h0);
		end
	endtask

	task press(input int n);
		@(posedge pclk);
		key_in[n] <= 1'b1;
		repeat (6) @(posedge pclk);
		key_in[n] <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask

	task complete_run;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial
	begin
		#200000;
		n_fail++;
		complete_run;
	end

	initial
	begin
		presetn = 1'b0;
		key_in = '0;
		talk_key = 1'b0;
		n_fail = 0;
		checked = 0;
		k = $urandom(32'hf0acf415);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(`ZKIL_REG_CTRL);
		chk(q, 32'h2);
		wr(12'h020, 32'h1);
		chk(e, 1'b1);
		rd(12'h020);
		chk(q, 32'h0);
		$display("register test done");
		for (int i = 0; i < 18; i++)
		begin
			z = (i < 12) ? 12'h001 << i : 12'($urandom);
			cfg(0, 32'h1, z);
			obs(0);
			chk(c, model(z));
		end
		$display("zone lamp test done");
		cfg(3, 32'h1, 12'h002);
		cfg(0, 32'h1, 12'h008);
		repeat (4) @(posedge pclk);
		k = 0;
		repeat (16)
		begin
			@(posedge pclk);
			k += ((key_rgb[0] == 3'h0) != (key_rgb[3] == 3'h0));
		end
		chk(k, 0);
		$display("blink phase test done");
		cfg(0, 32'h1, 12'h004);
		cfg(1, 32'h2, 12'h000);
		i_host.put_fail(1'b1);
		obs(1);
		chk(c, 4'hd);
		chk({fail_led, alert_out}, 2'h3);
		rd(`ZKIL_REG_STAT);
		chk(q, 32'h5);
		press(1);
		obs(1);
		chk(c, 4'hc);
		obs(0);
		chk(c, 4'hc);
		chk({fail_led, alert_out}, 2'h2);
		rd(`ZKIL_REG_STAT);
		chk(q, 32'h3);
		rd(`ZKIL_REG_LAMP);
		chk(q, 32'hc);
		rd(`ZKIL_REG_PRESS);
		chk(q, 32'h1);
		wr(`ZKIL_REG_PRESS, 32'h1);
		rd(`ZKIL_REG_PRESS);
		chk(q, 32'h0);
		i_host.put_fail(1'b0);
		obs(1);
		chk(c, 4'h1);
		chk(fail_led, 1'b0);
		$display("failure test done");
		for (int j = 0; j < 2; j++)
		begin
			k = j ? 4 + $urandom % 16 : 0;
			cfg(k, 32'h1, 12'h000);
			press(k);
			chk(key_sel_led[k], 1'b1);
			rd(`ZKIL_REG_SEL);
			chk(q, 32'h1);
			press(k);
			chk(key_sel_led[k], 1'b0);
		end
		$display("selection test done");
		for (int m = 0; m < 5; m++)
		begin
			cfg(2, 32'h4 | (m << 4), 12'h000);
			@(posedge pclk);
			key_in[2] <= 1'b1;
			k = 0;
			while (menu_valid !== 1'b1 && k < 10)
			begin
				@(posedge pclk);
				k++;
			end
			chk({k < 10, menu_cmd}, {1'b1, m[2:0]});
			key_in[2] <= 1'b0;
			repeat (8) @(posedge pclk);
		end
		$display("menu test done");
		cfg(7, 32'h3, 12'h000);
		wr(`ZKIL_REG_CTRL, 32'h3);
		talk_key <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(key_rgb[7], 3'h7);
		chk({&key_sel_led, fail_led, alert_out}, 3'h7);
		chk(talk_active, 1'b1);
		wr(`ZKIL_REG_CTRL, 32'h0);
		i_host.put_fail(1'b1);
		repeat (8) @(posedge pclk);
		chk({fail_led, alert_out}, 2'h2);
		i_host.put_fail(1'b0);
		talk_key <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({fail_led, |key_sel_led}, 2'h0);
		chk(talk_active, 1'b0);
		$display("indicator test done");
		complete_run;
	end
endmodule
